// [design/radio_cfg_pkg.sv]
// Constants for the serial configuration register bank.
// Assumes one 16-bit word per load, data first, address last.
package radio_cfg_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 14;
    localparam int CNT_W = 5;
    localparam logic [ADDR_W-1:0] PLL_CONFIGURATION_ADR = 2'h0;
    localparam logic [ADDR_W-1:0] CHANNEL_DIVIDE_RATIO_ADR = 2'h1;
    localparam logic [ADDR_W-1:0] TEST_MODE_SELECT_ADR = 2'h2;
    localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;
    // Field positions within a register word
    localparam int CHARGE_PUMP_POLARITY_BIT = 2;
    localparam int REF_DIVIDE_SELECT_LOW_BIT = 3;
    localparam int ANALOG_OUTPUT_SELECT_BIT = 4;
    localparam int REF_DIVIDE_SELECT_HIGH_BIT = 5;
    localparam int CARRIER_ONLY_TEST_BIT = 6;
    localparam int TX_POWER_DRAIN_CONTROL_BIT = 7;
    localparam int TX_BUFFER_FOLLOW_MODE_BIT = 8;
    localparam int SUPPLY_LOCKOUT_ENABLE_BIT = 10;
    localparam int SIGNAL_LEVEL_CLIP_DISABLE_BIT = 11;
    localparam int CHANNEL_DIVIDE_LSB = 2;
    localparam int CHANNEL_DIVIDE_W = 12;
    localparam int ANALOG_TEST_LSB = 2;
    localparam int DIGITAL_TEST_LSB = 5;
    localparam int TEST_W = 3;
    // Reference divide ratios by (low, high) select code
    localparam logic [4:0] REF_DIV_00 = 5'h09;
    localparam logic [4:0] REF_DIV_01 = 5'h0c;
    localparam logic [4:0] REF_DIV_10 = 5'h12;
    localparam logic [4:0] REF_DIV_11 = 5'h18;
endpackage : radio_cfg_pkg

// [design/radio_serial_config_registers.sv]
// Serial-loaded configuration registers and their pin controls.
// Assumes sclk is the host serial clock; clk is the core clock; rst is power-on.
//
// What this block does
// - Last two bits shifted form the address; earlier bits form the data.
// - Load strobe rising edge writes the data to the addressed register.
// - Only the newest sixteen shifted bits are used on load.
// - Power-on clears all register bits to zero.
// - Bit 2 of register zero selects charge pump polarity.
// - Bits 3 and 5 select reference divide 9, 12, 18 or 24.
// - Bit 4 selects analog pin: power control or data filter output.
// - Bit 6 selects carrier-only transmit while receive-on is low.
// - With analog select and analog test select 0, bit 7 pulls open-drain pin low when set.
// - Power control value reaches the pin only on receive-on falling edge.
// - Bit 8 makes the transmit buffer follow PA enable; keep zero normally.
// - Bit 10 arms a low-supply latch that forces PA enable low, except when bit 7 of register two reroutes the PA pin.
// - Receive-on going high clears the low-supply latch.
// - Bit 11 disables signal strength clipping.
// - Bits 2 to 13 of register one hold the channel divide value.
// - Register two holds digital and analog test selects; rest reserved.
// - Strobe low shifts data on rising serial clock; strobe high ignores it.
// - Analog test select is bits 2 to 4; nonzero makes test ports.
// - Digital test select is bits 5 to 7 of register two.
// - Nonzero digital test select reroutes data pin; PA enable pin only when bit 7 is set.
`timescale 1ns/1ps
module radio_serial_config_registers
    import radio_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic receive_on_input,
    input wire logic supply_low,
    input wire logic pa_request,
    input wire logic rx_data,
    input wire logic [1:0] digital_test_signals,
    output logic charge_pump_polarity,
    output logic [4:0] ref_divide_ratio,
    output logic analog_output_select,
    output logic carrier_only_active,
    output logic analog_pin_drain_o,
    output logic analog_pin_drain_oe,
    output logic tx_buffer_follow_mode,
    output logic signal_level_clip_disable,
    output logic [CHANNEL_DIVIDE_W-1:0] channel_divide_value,
    output logic [TEST_W-1:0] analog_test_select,
    output logic [TEST_W-1:0] digital_test_select,
    output logic analog_test_ports,
    output logic pa_enable_output,
    output logic rx_data_output
);
    // Serial domain: shift register and load capture
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] pll_configuration_r;
    logic [WORD_W-1:0] channel_divide_ratio_r;
    logic [WORD_W-1:0] test_mode_select_r;
    logic [CNT_W-1:0] bits_r;

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            shift_r <= REG_RESET;
        end else if (!load_strobe) begin
            shift_r <= {shift_r[WORD_W-2:0], sdata};
        end
    end

    // Bit counter for checking only; strobe high clears it
    always_ff @(posedge sclk or posedge rst or posedge load_strobe) begin
        if (rst || load_strobe) begin
            bits_r <= '0;
        end else if (bits_r != CNT_W'(WORD_W)) begin
            bits_r <= bits_r + 1'b1;
        end
    end

    // Load toggle, handed to the core clock
    logic load_tog_r;
    always_ff @(posedge load_strobe or posedge rst) begin
        if (rst) begin
            load_tog_r <= 1'b0;
        end else begin
            load_tog_r <= !load_tog_r;
        end
    end

    // Strobe edge loads the addressed register
    always_ff @(posedge load_strobe or posedge rst) begin
        if (rst) begin
            pll_configuration_r <= REG_RESET;
            channel_divide_ratio_r <= REG_RESET;
            test_mode_select_r <= REG_RESET;
        end else begin
            case (shift_r[ADDR_W-1:0])
                PLL_CONFIGURATION_ADR: begin
                    pll_configuration_r <= {2'h0, shift_r[WORD_W-1:ADDR_W]};
                end
                CHANNEL_DIVIDE_RATIO_ADR: begin
                    channel_divide_ratio_r <= {2'h0, shift_r[WORD_W-1:ADDR_W]};
                end
                TEST_MODE_SELECT_ADR: begin
                    test_mode_select_r <= {2'h0, shift_r[WORD_W-1:ADDR_W]};
                end
                default: begin
                end
            endcase
        end
    end

    // Data-field views, register bit n is data bit n-2
    logic [DATA_W-1:0] pll_d;
    logic [DATA_W-1:0] chan_d;
    logic [DATA_W-1:0] test_d;
    assign pll_d = pll_configuration_r[DATA_W-1:0];
    assign chan_d = channel_divide_ratio_r[DATA_W-1:0];
    assign test_d = test_mode_select_r[DATA_W-1:0];

    // Crossing into core clock: load toggle synced, then words taken whole
    logic [DATA_W-1:0] pll_s2_r;
    logic [DATA_W-1:0] chan_s2_r;
    logic [DATA_W-1:0] test_s2_r;
    logic [2:0] load_sync_r;
    logic [2:0] recv_sync_r;
    logic [1:0] low_sync_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_sync_r <= '0;
        end else begin
            load_sync_r <= {load_sync_r[1:0], load_tog_r};
        end
    end

    // Words are quiet once the toggle has passed two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_s2_r <= '0;
            chan_s2_r <= '0;
            test_s2_r <= '0;
        end else if (load_sync_r[2] != load_sync_r[1]) begin
            pll_s2_r <= pll_d;
            chan_s2_r <= chan_d;
            test_s2_r <= test_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            recv_sync_r <= '0;
            low_sync_r <= '0;
        end else begin
            recv_sync_r <= {recv_sync_r[1:0], receive_on_input};
            low_sync_r <= {low_sync_r[0], supply_low};
        end
    end

    // Register field decode in core domain
    localparam int O = ADDR_W;
    logic recv_q;
    logic recv_fall;
    logic recv_rise;
    logic [1:0] ref_sel;
    logic [TEST_W-1:0] ana_test;
    logic [TEST_W-1:0] dig_test;
    assign recv_q = recv_sync_r[1];
    assign recv_fall = recv_sync_r[2] && !recv_sync_r[1];
    assign recv_rise = !recv_sync_r[2] && recv_sync_r[1];
    assign ref_sel = {pll_s2_r[REF_DIVIDE_SELECT_LOW_BIT-O],
                      pll_s2_r[REF_DIVIDE_SELECT_HIGH_BIT-O]};
    assign ana_test = test_s2_r[ANALOG_TEST_LSB-O +: TEST_W];
    assign dig_test = test_s2_r[DIGITAL_TEST_LSB-O +: TEST_W];

    // Plain configuration outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_pump_polarity <= 1'b0;
            analog_output_select <= 1'b0;
            tx_buffer_follow_mode <= 1'b0;
            signal_level_clip_disable <= 1'b0;
            channel_divide_value <= '0;
            analog_test_select <= '0;
            digital_test_select <= '0;
            analog_test_ports <= 1'b0;
            carrier_only_active <= 1'b0;
        end else begin
            charge_pump_polarity <= pll_s2_r[CHARGE_PUMP_POLARITY_BIT-O];
            analog_output_select <= pll_s2_r[ANALOG_OUTPUT_SELECT_BIT-O];
            tx_buffer_follow_mode <= pll_s2_r[TX_BUFFER_FOLLOW_MODE_BIT-O];
            signal_level_clip_disable <= pll_s2_r[SIGNAL_LEVEL_CLIP_DISABLE_BIT-O];
            channel_divide_value <= chan_s2_r[CHANNEL_DIVIDE_LSB-O +: CHANNEL_DIVIDE_W];
            analog_test_select <= ana_test;
            digital_test_select <= dig_test;
            analog_test_ports <= (ana_test != '0);
            carrier_only_active <= pll_s2_r[CARRIER_ONLY_TEST_BIT-O] && !recv_q;
        end
    end

    // Reference divide ratio
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_divide_ratio <= REF_DIV_00;
        end else begin
            case (ref_sel)
                2'h0: ref_divide_ratio <= REF_DIV_00;
                2'h1: ref_divide_ratio <= REF_DIV_01;
                2'h2: ref_divide_ratio <= REF_DIV_10;
                default: ref_divide_ratio <= REF_DIV_11;
            endcase
        end
    end

    // Open-drain power control, applied at receive-on falling edge
    logic drain_applied_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drain_applied_r <= 1'b0;
        end else if (recv_fall) begin
            drain_applied_r <= pll_s2_r[TX_POWER_DRAIN_CONTROL_BIT-O];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_pin_drain_o <= 1'b0;
            analog_pin_drain_oe <= 1'b0;
        end else begin
            analog_pin_drain_o <= 1'b0;
            analog_pin_drain_oe <= !analog_output_select && (ana_test == '0)
                && drain_applied_r;
        end
    end

    // Low-supply lockout latch; set wins over clear
    logic lockout_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lockout_r <= 1'b0;
        end else if (pll_s2_r[SUPPLY_LOCKOUT_ENABLE_BIT-O] && low_sync_r[1]) begin
            lockout_r <= 1'b1;
        end else if (recv_rise) begin
            lockout_r <= 1'b0;
        end
    end

    // PA enable and data output, with digital test routing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pa_enable_output <= 1'b0;
            rx_data_output <= 1'b0;
        end else if (dig_test != '0) begin
            pa_enable_output <= dig_test[2] ? digital_test_signals[0]
                : pa_request && !lockout_r;
            rx_data_output <= digital_test_signals[1];
        end else begin
            pa_enable_output <= pa_request && !lockout_r;
            rx_data_output <= rx_data;
        end
    end

    // Checks
    property p_lockout_blocks_pa;
        @(posedge clk) disable iff (rst)
            (lockout_r && dig_test == '0) |=> !pa_enable_output;
    endproperty
    a_lockout_blocks_pa: assert property (p_lockout_blocks_pa)
        else $error("pa on in lockout");

    property p_lockout_clears;
        @(posedge clk) disable iff (rst)
            (recv_rise && !(pll_s2_r[SUPPLY_LOCKOUT_ENABLE_BIT-O] && low_sync_r[1]))
            |=> !lockout_r;
    endproperty
    a_lockout_clears: assert property (p_lockout_clears)
        else $error("lockout not cleared");

    property p_drain_holds;
        @(posedge clk) disable iff (rst)
            !recv_fall |=> $stable(drain_applied_r);
    endproperty
    a_drain_holds: assert property (p_drain_holds)
        else $error("power control moved off edge");

    property p_drain_value;
        @(posedge clk) disable iff (rst)
            1'b1 |=> !analog_pin_drain_o;
    endproperty
    a_drain_value: assert property (p_drain_value) else $error("drain drove high");

    property p_cw_only_rx_low;
        @(posedge clk) disable iff (rst)
            carrier_only_active |-> $past(!recv_q);
    endproperty
    a_cw_only_rx_low: assert property (p_cw_only_rx_low)
        else $error("carrier mode in rx");

    property p_ana_ports;
        @(posedge clk) disable iff (rst)
            (ana_test != '0) |=> analog_test_ports;
    endproperty
    a_ana_ports: assert property (p_ana_ports) else $error("test ports off");

    property p_shift_hold;
        @(posedge sclk) disable iff (rst)
            load_strobe |=> $stable(shift_r);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift while strobe high");

    property p_shift_in;
        @(posedge sclk) disable iff (rst)
            !load_strobe |=> shift_r[0] == $past(sdata);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("bit not shifted");

    property p_ref_div;
        @(posedge clk) disable iff (rst)
            (ref_sel == 2'h3) |=> ref_divide_ratio == REF_DIV_11;
    endproperty
    a_ref_div: assert property (p_ref_div) else $error("wrong divide");

    property p_full_word;
        @(posedge load_strobe) disable iff (rst)
            1'b1 |-> bits_r == CNT_W'(WORD_W);
    endproperty
    a_full_word: assert property (p_full_word) else $error("short word loaded");

    property p_analog_mode_no_drain;
        @(posedge clk) disable iff (rst)
            (analog_output_select || ana_test != '0) |=> !analog_pin_drain_oe;
    endproperty
    a_analog_mode_no_drain: assert property (p_analog_mode_no_drain)
        else $error("drain on in analog mode");

    property p_test_data_route;
        @(posedge clk) disable iff (rst)
            (dig_test != '0) |=> rx_data_output == $past(digital_test_signals[1]);
    endproperty
    a_test_data_route: assert property (p_test_data_route)
        else $error("test data not routed");

    property p_pa_follows;
        @(posedge clk) disable iff (rst)
            (dig_test == '0 && !lockout_r) |=> pa_enable_output == $past(pa_request);
    endproperty
    a_pa_follows: assert property (p_pa_follows)
        else $error("pa not following request");

    property p_ana_ports_off;
        @(posedge clk) disable iff (rst)
            (ana_test == '0) |=> !analog_test_ports;
    endproperty
    a_ana_ports_off: assert property (p_ana_ports_off) else $error("test ports on");
endmodule : radio_serial_config_registers

// [test/host_serial_model.sv]
// Host side model of the three-wire configuration port.
// Assumes the bench calls its tasks; serial clock idles low between frames.
`timescale 1ns/1ps
module host_serial_model (
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b1;
    end
    // One bit, set up while clock low, taken on rise
    task automatic shift_bit(input logic b);
        sdata = b;
        #24;
        sclk = 1'b1;
        #24;
        sclk = 1'b0;
    endtask : shift_bit
    // Frame of n bits, newest last, strobe raised after last rise
    task automatic frame(input logic [19:0] w, input int n);
        load_strobe = 1'b0;
        #24;
        for (int i = n - 1; i >= 0; i--) begin
            shift_bit(w[i]);
        end
        load_strobe = 1'b1;
        sdata = ~sdata;
        #120;
    endtask : frame
    // Whole word, address in the last two bits
    task automatic send_word(input logic [15:0] w);
        frame({4'h0, w}, 16);
    endtask : send_word
    // Four stale bits ahead of a whole word
    task automatic send_long(input logic [3:0] junk, input logic [15:0] w);
        frame({junk, w}, 20);
    endtask : send_long
    // Clock pulses with the strobe high, to be ignored
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            shift_bit(1'b1);
        end
    endtask : stray
endmodule : host_serial_model

// [test/tb.sv]
// Self-checking bench for the serial configuration register bank.
// Assumes the host model drives the serial pins; core inputs driven here.
`timescale 1ns/1ps
module tb;
    import radio_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, sdata, load_strobe;
    logic receive_on_input = 1'b1;
    logic supply_low = 1'b0;
    logic pa_request = 1'b0;
    logic rx_data = 1'b0;
    logic [1:0] digital_test_signals = 2'h0;
    logic cpp, aos, cw, drain_o, drain_oe, tbuf, clip, atp, pa, rxo;
    logic [4:0] rdiv;
    logic [CHANNEL_DIVIDE_W-1:0] chan;
    logic [TEST_W-1:0] ana_sel, dig_sel;
    int failures = 0;
    int n_tests = 0;
    logic [4:0] exp_div [4] = '{5'h09, 5'h0c, 5'h12, 5'h18};
    always #50 clk = ~clk;
    host_serial_model u_host_serial_model (.sclk(sclk), .sdata(sdata),
        .load_strobe(load_strobe));
    radio_serial_config_registers u_radio_serial_config_registers (
        .clk(clk), .rst(rst), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
        .receive_on_input(receive_on_input), .supply_low(supply_low),
        .pa_request(pa_request), .rx_data(rx_data),
        .digital_test_signals(digital_test_signals), .charge_pump_polarity(cpp),
        .ref_divide_ratio(rdiv), .analog_output_select(aos), .carrier_only_active(cw),
        .analog_pin_drain_o(drain_o), .analog_pin_drain_oe(drain_oe),
        .tx_buffer_follow_mode(tbuf),
        .signal_level_clip_disable(clip), .channel_divide_value(chan),
        .analog_test_select(ana_sel), .digital_test_select(dig_sel), .analog_test_ports(atp),
        .pa_enable_output(pa), .rx_data_output(rxo));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // Let the synchronisers and output flops settle
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [15:0] w);
        u_host_serial_model.send_word(w);
        settle();
    endtask : wr
    initial begin
        #2_000_000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        settle();
        chk({rdiv, cpp, aos, cw, drain_oe, tbuf, clip, atp, pa}, {5'h09, 8'h00});
        chk({chan, ana_sel[0], dig_sel[0], drain_o, rxo}, 16'h0000);
        chk({10'h0, ana_sel, dig_sel}, 16'h0000);
        // Reserved bits written as zero throughout
        for (int k = 0; k < 4; k++) begin
            wr({4'h0, k[1], 2'b00, k[0], 2'b00, k[0], k[1], k[1], k[0], 2'b00});
            chk({rdiv, cpp, aos, tbuf, clip}, {exp_div[k], k[0], k[1], k[0], k[1]});
            chk({15'h0, cpp}, {15'h0, k[0]});
        end
        wr(16'h0080);
        chk({drain_o, drain_oe, aos}, 3'h0);
        step();
        receive_on_input = 1'b0;
        settle();
        chk({drain_o, drain_oe}, 2'h1);
        wr(16'h0040);
        chk({cw, drain_oe}, 2'h3);
        step();
        receive_on_input = 1'b1;
        settle();
        chk({cw, drain_oe}, 2'h1);
        step();
        receive_on_input = 1'b0;
        settle();
        chk({cw, drain_oe}, 2'h2);
        step();
        receive_on_input = 1'b1;
        pa_request = 1'b1;
        wr(16'h0400);
        chk({15'h0, pa}, 16'h0001);
        step();
        supply_low = 1'b1;
        settle();
        chk({15'h0, pa}, 16'h0000);
        step();
        supply_low = 1'b0;
        settle();
        chk({15'h0, pa}, 16'h0000);
        step();
        receive_on_input = 1'b0;
        step();
        receive_on_input = 1'b1;
        settle();
        chk({15'h0, pa}, 16'h0001);
        wr(16'h0000);
        step();
        supply_low = 1'b1;
        settle();
        chk({15'h0, pa}, 16'h0001);
        step();
        supply_low = 1'b0;
        u_host_serial_model.send_long(4'hf, {2'b00, 12'd1600, 2'b01});
        settle();
        chk({chan, rdiv[3:0]}, {12'd1600, 4'h9});
        wr({2'b00, 12'd1589, 2'b11});
        chk({4'h0, chan}, {4'h0, 12'd1600});
        step();
        digital_test_signals = 2'h2;
        wr(16'h0096);
        chk({7'h0, ana_sel, dig_sel, atp, pa, rxo}, {7'h0, 3'h5, 3'h4, 3'h5});
        step();
        digital_test_signals = 2'h1;
        rx_data = 1'b1;
        u_host_serial_model.stray(4);
        wr(16'h0002);
        chk({7'h0, ana_sel, dig_sel, atp, pa, rxo}, 16'h0003);
        give_verdict();
    end
endmodule : tb
